//--- core/ssel_pkg.sv
// Constants, carriers and helpers for the sync source selection block.
// Assumes a single clock and an APB register port with word addressing.
package ssel_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;
    localparam int SEL_W  = 3;
    localparam int IDX_W  = 6;
    localparam int N_CONS = 13;

    // ****************************************************************
    // Register indices; the byte address is four times the index
    // ****************************************************************
    localparam logic [IDX_W-1:0] IDX_GLOBAL   = 6'h01;
    localparam logic [IDX_W-1:0] IDX_CHANNEL  = 6'h15;
    localparam logic [IDX_W-1:0] IDX_CICMIX_A = 6'h16;
    localparam logic [IDX_W-1:0] IDX_CICMIX_B = 6'h1E;
    localparam logic [IDX_W-1:0] IDX_MODE     = 6'h17;
    localparam logic [IDX_W-1:0] IDX_STATUS   = 6'h18;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [REG_W-1:0] RST_GLOBAL   = 16'h0000;
    localparam logic [REG_W-1:0] RST_CHANNEL  = 16'h0000;
    localparam logic [REG_W-1:0] RST_CICMIX_A = 16'h0000;
    localparam logic [REG_W-1:0] RST_CICMIX_B = 16'h0000;
    localparam logic [REG_W-1:0] RST_MODE     = 16'h0000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int F_ALIGN_OUT = 0;
    localparam int F_OS_FIRE   = 4;
    localparam int F_OS_LEVEL  = 5;
    localparam int F_FIR       = 0;
    localparam int F_COEF      = 3;
    localparam int F_GAIN      = 6;
    localparam int F_PWR       = 9;
    localparam int F_SCK       = 12;
    localparam int F_FREQ      = 0;
    localparam int F_PHASE     = 3;
    localparam int F_DITH      = 6;
    localparam int F_NCO       = 9;
    localparam int F_FLUSH     = 12;
    localparam int F_CIC       = 0;
    localparam int F_ZPAD      = 3;
    localparam int F_HOLD      = 6;
    localparam int F_RX_INTERP = 0;
    localparam int F_IQ_MUX    = 1;
    localparam int F_ST_EXT_A  = 13;
    localparam int F_ST_EXT_B  = 14;
    localparam int F_ST_OS     = 15;

    // ****************************************************************
    // Source codes
    // ****************************************************************
    localparam logic [SEL_W-1:0] SEL_OFF0     = 3'h0;
    localparam logic [SEL_W-1:0] SEL_OFF1     = 3'h1;
    localparam logic [SEL_W-1:0] SEL_EXT_A    = 3'h2;
    localparam logic [SEL_W-1:0] SEL_EXT_B    = 3'h3;
    localparam logic [SEL_W-1:0] SEL_ONE_SHOT = 3'h4;
    localparam logic [SEL_W-1:0] SEL_TIMER    = 3'h5;
    localparam logic [SEL_W-1:0] SEL_ON6      = 3'h6;
    localparam logic [SEL_W-1:0] SEL_ON7      = 3'h7;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic ext_a;
        logic ext_b;
        logic one_shot;
        logic timer_tc;
    } ssel_src_t;

    typedef struct packed {
        logic fir;
        logic cic;
        logic coef;
        logic sck;
        logic zpad;
        logic hold;
        logic nco;
        logic gain;
        logic dith;
        logic flush;
        logic pwr;
        logic freq;
        logic phase;
    } ssel_evt_t;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic ssel_pick(input logic [SEL_W-1:0] sel,
                                       input ssel_src_t       src);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            SEL_OFF0, SEL_OFF1: hit = 1'b0;
            SEL_EXT_A:          hit = src.ext_a;
            SEL_EXT_B:          hit = src.ext_b;
            SEL_ONE_SHOT:       hit = src.one_shot;
            SEL_TIMER:          hit = src.timer_tc;
            SEL_ON6, SEL_ON7:   hit = 1'b1;
        endcase
        return hit;
    endfunction : ssel_pick

    function automatic logic [SEL_W-1:0] ssel_field(
        input logic [REG_W-1:0] r,
        input int               pos);
        return r[pos +: SEL_W];
    endfunction : ssel_field

endpackage : ssel_pkg

//--- core/ssel_route.sv
// Per-consumer source selection with one register stage per consumer.
// Assumes the sources are already active high and synchronous to pclk.
`timescale 1ns/10ps
module ssel_route #(
    parameter int N = 13
) (
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // Selection and sources
    input  wire logic [N-1:0][ssel_pkg::SEL_W-1:0] sel,
    input  wire ssel_pkg::ssel_src_t           src,
    // Registered sync events
    output logic      [N-1:0]                  evt
);
    import ssel_pkg::*;

    typedef struct packed {
        logic [N-1:0] evt;
    } ssel_route_st_t;

    ssel_route_st_t st;
    ssel_route_st_t next_st;

    // ****************************************************************
    // Selection
    // ****************************************************************
    always_comb
    begin
        next_st = st;
        for (int i = 0; i < N; i++)
        begin
            next_st.evt[i] = ssel_pick(sel[i], src);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign evt = st.evt;

endmodule : ssel_route

//--- core/ssel_top.sv
// Sync source selection: registers, input sampling, one-shot, sync out.
// Assumes sync pins and the timer count are synchronous to pclk and that
// the APB master keeps to the usual setup and access phases.
//
// Notes on behaviour
// - each consumer picks a source by 3-bit code; 0,1 off, 6,7 on.
// - sync pins are active low and inverted to active-high internal syncs.
// - one-shot runs either as a held level or as a single pulse.
// - sync output pin source chosen by a field in the global register.
// - filter sync restarts decimation phase, address generators and FSMs.
// - zero-pad sync acts only with receive interpolation or IQ mux input.
// - CIC sync aligns the CIC decimation phase.
// - coefficient sync times the switch between the two coefficient banks.
// - output clock sync aligns the divided receive output clock.
// - hold sync aligns decimation of real or parallel IQ output data.
// - NCO sync applies pending NCO updates; input B is suggested.
// - flush sync zeroes the CIC integrators; usually never repeated.
// - power meter sync starts a new I squared plus Q squared sum.
// - dither free-runs when sync is off and freezes when always on.
// - sync input A is sampled on the clock and must be synchronous.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module ssel_top #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB slave
    input  wire logic [ADDR_W-1:0]            paddr,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ssel_pkg::DATA_W-1:0]  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [ssel_pkg::DATA_W-1:0]  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Sync pins and timer
    input  wire logic                         ext_align_in_a_n,
    input  wire logic                         ext_align_in_b_n,
    input  wire logic                         timer_terminal_count,
    output logic                              align_out_n,
    // Sync events to the consumers
    output ssel_pkg::ssel_evt_t               sync_evt
);
    import ssel_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [REG_W-1:0]  glob;
        logic [REG_W-1:0]  chan;
        logic [REG_W-1:0]  cma;
        logic [REG_W-1:0]  cmb;
        logic [REG_W-1:0]  mode;
        logic              os_pulse;
        logic              src_a;
        logic              src_b;
        logic              src_tc;
        logic              align_out_n;
        logic [DATA_W-1:0] rdata;
    } ssel_st_t;

    ssel_st_t                     st;
    ssel_st_t                     next_st;
    ssel_src_t                    src;
    logic [N_CONS-1:0][SEL_W-1:0] sel;
    logic [N_CONS-1:0]            evt_raw;
    logic [IDX_W-1:0]             idx;
    logic                         mapped;
    logic                         wr_en;
    logic                         rd_setup;
    logic [REG_W-1:0]             wmask;
    logic                         zpad_ok;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    assign idx = paddr[IDX_W+1:2];

    always_comb
    begin
        unique case (idx)
            IDX_GLOBAL, IDX_CHANNEL, IDX_CICMIX_A, IDX_CICMIX_B,
            IDX_MODE, IDX_STATUS: mapped = (paddr[1:0] == 2'h0);
            default:              mapped = 1'b0;
        endcase
    end

    assign wr_en    = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign wmask    = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // Zero wait states: read data is captured in the setup cycle.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = st.rdata;

    // ****************************************************************
    // Sources
    // ****************************************************************
    assign src.ext_a    = st.src_a;
    assign src.ext_b    = st.src_b;
    assign src.timer_tc = st.src_tc;
    assign src.one_shot = st.glob[F_OS_LEVEL] ? st.glob[F_OS_FIRE]
                                              : st.os_pulse;

    // zero-pad only in interpolated or multiplexed input
    assign zpad_ok = st.mode[F_RX_INTERP] || st.mode[F_IQ_MUX];

    // ****************************************************************
    // Consumer selection, in the bit order of the event carrier
    // ****************************************************************
    always_comb
    begin
        sel[12] = ssel_field(st.chan, F_FIR);
        sel[11] = ssel_field(st.cmb, F_CIC);
        sel[10] = ssel_field(st.chan, F_COEF);
        sel[9]  = ssel_field(st.chan, F_SCK);
        sel[8]  = zpad_ok ? ssel_field(st.cmb, F_ZPAD) : SEL_OFF0;
        sel[7]  = ssel_field(st.cmb, F_HOLD);
        sel[6]  = ssel_field(st.cma, F_NCO);
        sel[5]  = ssel_field(st.chan, F_GAIN);
        sel[4]  = ssel_field(st.cma, F_DITH);
        sel[3]  = ssel_field(st.cma, F_FLUSH);
        sel[2]  = ssel_field(st.chan, F_PWR);
        sel[1]  = ssel_field(st.cma, F_FREQ);
        sel[0]  = ssel_field(st.cma, F_PHASE);
    end

    ssel_route #(
        .N       (N_CONS)
    ) u_route (
        .pclk    (pclk),
        .presetn (presetn),
        .sel     (sel),
        .src     (src),
        .evt     (evt_raw)
    );

    assign sync_evt = ssel_evt_t'(evt_raw);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_st = st;

        next_st.src_a  = ~ext_align_in_a_n;
        next_st.src_b  = ~ext_align_in_b_n;
        next_st.src_tc = timer_terminal_count;

        // sync output source and pin drive
        next_st.align_out_n = ~ssel_pick(ssel_field(st.glob, F_ALIGN_OUT),
                                         src);

        // a pulse lasts one cycle only
        next_st.os_pulse = 1'b0;

        if (wr_en)
        begin
            unique case (idx)
                IDX_GLOBAL:
                begin
                    next_st.glob = (st.glob & ~wmask)
                                 | (pwdata[REG_W-1:0] & wmask);
                    // pulse mode fires once and self-clears
                    if (!next_st.glob[F_OS_LEVEL])
                    begin
                        next_st.os_pulse = next_st.glob[F_OS_FIRE];
                        next_st.glob[F_OS_FIRE] = 1'b0;
                    end
                end
                IDX_CHANNEL:
                    next_st.chan = (st.chan & ~wmask)
                                 | (pwdata[REG_W-1:0] & wmask);
                IDX_CICMIX_A:
                    next_st.cma = (st.cma & ~wmask)
                                | (pwdata[REG_W-1:0] & wmask);
                IDX_CICMIX_B:
                    next_st.cmb = (st.cmb & ~wmask)
                                | (pwdata[REG_W-1:0] & wmask);
                IDX_MODE:
                    next_st.mode = (st.mode & ~wmask)
                                 | (pwdata[REG_W-1:0] & wmask);
                default:
                    next_st.mode = st.mode;
            endcase
        end

        // ************************************************************
        // Read capture
        // ************************************************************
        if (rd_setup)
        begin
            next_st.rdata = '0;
            unique case (idx)
                IDX_GLOBAL:   next_st.rdata[REG_W-1:0] = st.glob;
                IDX_CHANNEL:  next_st.rdata[REG_W-1:0] = st.chan;
                IDX_CICMIX_A: next_st.rdata[REG_W-1:0] = st.cma;
                IDX_CICMIX_B: next_st.rdata[REG_W-1:0] = st.cmb;
                IDX_MODE:     next_st.rdata[REG_W-1:0] = st.mode;
                IDX_STATUS:
                begin
                    next_st.rdata[N_CONS-1:0] = evt_raw;
                    next_st.rdata[F_ST_EXT_A] = st.src_a;
                    next_st.rdata[F_ST_EXT_B] = st.src_b;
                    next_st.rdata[F_ST_OS]    = src.one_shot;
                end
                default:      next_st.rdata = '0;
            endcase
            // A refused read returns zero, even at a known index.
            if (!mapped)
                next_st.rdata = '0;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // The pin sits high in reset so peers see no sync until the
    // selected source says otherwise.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st             <= '0;
            st.glob        <= RST_GLOBAL;
            st.chan        <= RST_CHANNEL;
            st.cma         <= RST_CICMIX_A;
            st.cmb         <= RST_CICMIX_B;
            st.mode        <= RST_MODE;
            st.align_out_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign align_out_n = st.align_out_n;

endmodule : ssel_top

//--- verification/ssel_sync_gen.sv
// Behavioural sync generator standing at the far side of the sync pins.
// Assumes the bench calls its tasks; pins start inactive and hold the last level set between calls.
`timescale 1ns/10ps
module ssel_sync_gen (
    // Clock
    input  wire logic pclk,
    // Sync pins and timer count
    output logic      ext_align_in_a_n,
    output logic      ext_align_in_b_n,
    output logic      timer_terminal_count
);
    // ********
    // Pin drivers
    // ********
    initial
    begin
        ext_align_in_a_n     = 1'b1;
        ext_align_in_b_n     = 1'b1;
        timer_terminal_count = 1'b0;
    end

    task automatic set_lvl(input logic a, input logic b, input logic t);
        @(posedge pclk);
        ext_align_in_a_n     <= !a;
        ext_align_in_b_n     <= !b;
        timer_terminal_count <= t;
    endtask : set_lvl

    task automatic pulse_a;
        @(posedge pclk);
        ext_align_in_a_n <= 1'b0;
        @(posedge pclk);
        ext_align_in_a_n <= 1'b1;
    endtask : pulse_a
endmodule : ssel_sync_gen

//--- verification/ssel_monitor.sv
// Concurrent checks on the ports of the sync source selection block.
// Assumes it is bound into ssel_top; selectors are shadowed from APB.
`timescale 1ns/10ps
module ssel_monitor #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic                        pclk,
    input wire logic                        presetn,
    // APB slave
    input wire logic [ADDR_W-1:0]           paddr,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [ssel_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0]                  pstrb,
    input wire logic [ssel_pkg::DATA_W-1:0] prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    // Sync pins, timer and events
    input wire logic                        ext_align_in_a_n,
    input wire logic                        ext_align_in_b_n,
    input wire logic                        timer_terminal_count,
    input wire logic                        align_out_n,
    input wire ssel_pkg::ssel_evt_t         sync_evt
);
    import ssel_pkg::*;
    // ********
    // Selector shadows
    // ********
    logic             wr;
    logic [SEL_W-1:0] so_sel;
    logic [SEL_W-1:0] fir_sel;
    assign wr = psel && penable && pwrite && pready && pstrb[0];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            so_sel  <= SEL_OFF0;
            fir_sel <= SEL_OFF0;
        end
        else if (wr && paddr == {IDX_GLOBAL, 2'b00})
            so_sel <= pwdata[2:0];
        else if (wr && paddr == {IDX_CHANNEL, 2'b00})
            fir_sel <= pwdata[2:0];
    end

    // ********
    // Assertions
    // ********
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_so(logic [SEL_W-1:0] c);
        so_sel == c ##1 so_sel == c;
    endsequence
    sequence s_fir(logic [SEL_W-1:0] c);
        fir_sel == c ##1 fir_sel == c;
    endsequence

    chk_apb_ready: assert property (psel && penable |-> pready)
        else $error("access cycle without ready");
    chk_bad_addr: assert property (psel && penable && paddr[1:0] != 2'b00
        |-> pslverr) else $error("misaligned access not refused");
    chk_read_upper: assert property (psel && penable && !pwrite
        |-> prdata[31:16] == 16'h0000) else $error("read upper half set");
    chk_out_ext_a: assert property (s_so(SEL_EXT_A) |=>
        align_out_n == $past(ext_align_in_a_n, 2)) else $error("out vs A");
    chk_fir_ext_b: assert property (s_fir(SEL_EXT_B) |=>
        sync_evt.fir == !$past(ext_align_in_b_n, 2)) else $error("fir vs B");
    chk_fir_timer: assert property (s_fir(SEL_TIMER) |=>
        sync_evt.fir == $past(timer_terminal_count, 2)) else $error("tc");
    chk_fir_on: assert property ((fir_sel[2:1] == 2'b11) [*2]
        |=> sync_evt.fir) else $error("fir not always on");
    chk_fir_off: assert property ((fir_sel[2:1] == 2'b00) [*2]
        |=> !sync_evt.fir) else $error("fir not off");
    chk_os_pulse: assert property (wr && paddr == {IDX_GLOBAL, 2'b00}
        && pwdata[5:0] == 6'h14 |-> ##2 !align_out_n ##1 align_out_n)
        else $error("one-shot pulse wrong");
endmodule : ssel_monitor

bind ssel_top ssel_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_align_in_a_n(ext_align_in_a_n), .ext_align_in_b_n(ext_align_in_b_n),
    .timer_terminal_count(timer_terminal_count),
    .align_out_n(align_out_n), .sync_evt(sync_evt));

//--- verification/ssel_top_tb.sv
// Self-checking bench for the sync source selection block.
// Assumes ssel_sync_gen drives the sync pins and APB is word addressed.
`timescale 1ns/10ps
module ssel_top_tb;
    import ssel_pkg::*;
    // ********
    // Signals
    // ********
    localparam logic [7:0] A_GLB = {IDX_GLOBAL, 2'b00};
    localparam logic [7:0] A_CH  = {IDX_CHANNEL, 2'b00};
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic [3:0]        pstrb;
    logic              pready;
    logic              pslverr;
    logic              a_n;
    logic              b_n;
    logic              tc;
    logic              align_out_n;
    ssel_evt_t         sync_evt;
    int                mismatches;
    int                n_tests;

    ssel_top #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_align_in_a_n(a_n), .ext_align_in_b_n(b_n),
        .timer_terminal_count(tc), .align_out_n(align_out_n),
        .sync_evt(sync_evt));
    ssel_sync_gen gen (.pclk(pclk), .ext_align_in_a_n(a_n),
        .ext_align_in_b_n(b_n), .timer_terminal_count(tc));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ********
    // Shared tasks
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; reads compare data with d, both compare the error.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        check(32'(pslverr), 32'(e));
        if (!w)
            check(prdata, d);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wait_n(input int n);
        repeat (n) @(negedge pclk);
    endtask : wait_n

    // ********
    // Scenarios
    // ********
    task automatic test_reset;
        xfer(1'b0, A_GLB, 32'(RST_GLOBAL), 1'b0);
        xfer(1'b0, A_CH, 32'(RST_CHANNEL), 1'b0);
        xfer(1'b0, {IDX_CICMIX_A, 2'b00}, 32'(RST_CICMIX_A), 1'b0);
        xfer(1'b0, {IDX_CICMIX_B, 2'b00}, 32'(RST_CICMIX_B), 1'b0);
        xfer(1'b0, {IDX_MODE, 2'b00}, 32'(RST_MODE), 1'b0);
        check(32'(sync_evt), 32'h0);
        check(32'(align_out_n), 32'h1);
    endtask : test_reset

    task automatic test_codes;
        logic [7:0] on_a;
        logic [7:0] on_b;
        on_a = 8'hE4;
        on_b = 8'hC8;
        for (int c = 0; c < 8; c++)
        begin
            gen.set_lvl(1'b1, 1'b0, 1'b1);
            xfer(1'b1, A_CH, 32'(c), 1'b0);
            wait_n(4);
            check(32'(sync_evt.fir), 32'(on_a[c]));
            gen.set_lvl(1'b0, 1'b1, 1'b0);
            wait_n(4);
            check(32'(sync_evt.fir), 32'(on_b[c]));
            xfer(1'b0, A_CH, 32'(c), 1'b0);
        end
    endtask : test_codes

    task automatic test_fanout;
        ssel_evt_t exp;
        int        i;
        xfer(1'b1, A_GLB, 32'h2, 1'b0);
        xfer(1'b1, A_CH, 32'h2492, 1'b0);
        xfer(1'b1, {IDX_CICMIX_A, 2'b00}, 32'h2492, 1'b0);
        xfer(1'b1, {IDX_CICMIX_B, 2'b00}, 32'h0092, 1'b0);
        for (int m = 0; m < 3; m++)
        begin
            xfer(1'b1, {IDX_MODE, 2'b00}, 32'(m), 1'b0);
            exp = 13'h1FFF;
            exp.zpad = (m != 0);
            gen.pulse_a();
            i = 0;
            do
            begin
                @(negedge pclk);
                i++;
            end
            while (sync_evt.fir !== 1'b1 && i < 8);
            check(32'(sync_evt), 32'(exp));
            check(32'(align_out_n), 32'h0);
            @(negedge pclk);
            check(32'(sync_evt), 32'h0);
        end
    endtask : test_fanout

    task automatic test_one_shot;
        int lows;
        int hits;
        xfer(1'b1, A_CH, 32'h0100, 1'b0);
        xfer(1'b1, A_GLB, 32'h04, 1'b0);
        xfer(1'b1, A_GLB, 32'h14, 1'b0);
        lows = 0;
        hits = 0;
        for (int i = 0; i < 8; i++)
        begin
            @(negedge pclk);
            lows += (align_out_n === 1'b0);
            hits += (sync_evt.gain === 1'b1);
        end
        check(32'(lows), 32'h1);
        check(32'(hits), 32'h1);
        xfer(1'b0, A_GLB, 32'h04, 1'b0);
        xfer(1'b1, A_GLB, 32'h34, 1'b0);
        wait_n(4);
        check(32'(align_out_n), 32'h0);
        xfer(1'b0, A_GLB, 32'h34, 1'b0);
        xfer(1'b1, A_GLB, 32'h24, 1'b0);
        wait_n(4);
        check(32'(align_out_n), 32'h1);
        xfer(1'b1, {IDX_CICMIX_A, 2'b00}, 32'h003F, 1'b0);
        wait_n(2);
        check(32'({sync_evt.freq, sync_evt.phase}), 32'h3);
    endtask : test_one_shot

    // Refused accesses must leave the global register untouched.
    task automatic test_errors;
        xfer(1'b0, 8'h08, 32'h0, 1'b1);
        xfer(1'b0, 8'h05, 32'h0, 1'b1);
        xfer(1'b1, 8'h08, 32'hFFFF, 1'b1);
        xfer(1'b1, 8'h06, 32'h0007, 1'b1);
        xfer(1'b0, {IDX_STATUS, 2'b00}, 32'h4003, 1'b0);
        xfer(1'b0, A_GLB, 32'h24, 1'b0);
    endtask : test_errors

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    initial
    begin
        #80000;
        mismatches++;
        stop_test();
    end

    initial
    begin
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        pstrb      = 4'hF;
        mismatches = 0;
        n_tests    = 0;
        gen.set_lvl(1'b1, 1'b0, 1'b0);
        repeat (11) @(posedge pclk);
        presetn <= 1'b1;
        gen.set_lvl(1'b0, 1'b0, 1'b0);
        test_reset();
        test_codes();
        test_fanout();
        test_one_shot();
        test_errors();
        stop_test();
    end
endmodule : ssel_top_tb
